// ==== testbench/ecc4_host_model.sv ====
// Host processor model: APB master for the result registers
// ============================================================
// Master
module ecc4_host_model
    import ecc4_pkg::*;
(
    // Clock
    input wire logic pclk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [19:0] paddr,
    output logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 20'h00000;
        pwdata = 32'h00000000;
    end
    // Bounded wait so a silent slave cannot hang the run
    task xfer(input logic w, input logic [19:0] a, input logic [31:0] wd,
              output logic [31:0] rd, output logic err, output logic ok);
        int n;
        ok = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20 && !ok; n++)
        begin
            @(posedge pclk);
            ok = pready;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : ecc4_host_model

// ==== testbench/ecc4_result_monitor.sv ====
// Checker for the fourth-sector result register block
// ============================================================
// Assertions
module ecc4_result_monitor
    import ecc4_pkg::*;
#(
    parameter int ADDR_W = 20
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Check input and interrupt
    input wire logic chk_valid,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [IDX_W-1:0] idx;
    logic mapped;
    logic wr_done;
    logic rd_main;
    logic rd_spare;
    assign idx = paddr[ADDR_W-1:2];
    assign mapped = idx inside {IDX_MAIN_RESULT, IDX_SPARE_RESULT,
        IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_FIX_COUNT, IDX_FAIL_COUNT};
    assign wr_done = pready && pwrite;
    assign rd_main = pready && !pwrite && idx == IDX_MAIN_RESULT;
    assign rd_spare = pready && !pwrite && idx == IDX_SPARE_RESULT;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_inside: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_main_reserved: assert property (rd_main |-> prdata[15:12] == 4'h0)
        else $error("main result reserved bits set");
    a_spare_code: assert property (rd_spare |-> prdata[15:5] == 11'h000)
        else $error("spare result reserved bits or code set");
    a_unmapped_err: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (pready && mapped |-> !pslverr)
        else $error("mapped access refused");
    // A mask write acts at its completing edge, a check two edges on
    a_irq_rise: assert property ($rose(irq) |-> $past(chk_valid, 2) || $past(wr_done))
        else $error("irq rose without cause");
    a_irq_fall: assert property ($fell(irq) |-> $past(wr_done))
        else $error("irq fell without a write");
    cover property (pready && pslverr);
    cover property ($rose(irq));
    cover property (wr_done && mapped);
endmodule : ecc4_result_monitor

bind ecc4_result_regs ecc4_result_monitor #(.ADDR_W(ADDR_W)) mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chk_valid(chk_valid), .irq(irq));

// ==== testbench/test_ecc4_result_regs.sv ====
// Testbench for the fourth-sector result register block
module test_ecc4_result_regs
    import ecc4_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata;
    logic chk_valid, chk_boot, chk_spare;
    logic [1:0] chk_status, chk_code;
    logic [7:0] chk_word;
    logic [3:0] chk_line;
    int failures = 0;
    int compares = 0;
    ecc4_result_regs #(.ADDR_W(20)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chk_valid(chk_valid), .chk_boot(chk_boot),
        .chk_spare(chk_spare), .chk_status(chk_status),
        .chk_word(chk_word), .chk_line(chk_line), .chk_code(chk_code),
        .irq(irq));
    ecc4_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;
    // ============================================================
    // Tasks
    task test_done;
        $display("comparisons %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, seen, exp);
        end
    endtask : check
    task acc(input logic w, input logic [17:0] idx, input logic [31:0] d,
             input logic exp_err);
        logic [31:0] rd;
        logic err, ok;
        host.xfer(w, {idx, 2'b00}, d, rd, err, ok);
        if (!ok)
        begin
            failures++;
            test_done();
        end
        if (!w)
            check(rd, d);
        check({31'h0, err}, {31'h0, exp_err});
    endtask : acc
    task fire(input logic b, input logic s, input logic [1:0] st,
              input logic [7:0] w, input logic [3:0] l, input logic [1:0] c);
        @(posedge pclk);
        chk_valid <= 1'b1;
        chk_boot <= b;
        chk_spare <= s;
        chk_status <= st;
        chk_word <= w;
        chk_line <= l;
        chk_code <= c;
        @(posedge pclk);
        chk_valid <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : fire
    task irq_is(input logic v);
        repeat (3) @(posedge pclk);
        check({31'h0, irq}, {31'h0, v});
    endtask : irq_is
    // ============================================================
    // Sequence
    initial
    begin
        presetn = 1'b0;
        {chk_valid, chk_boot, chk_spare, chk_status} = 5'h00;
        {chk_word, chk_line, chk_code} = 14'h0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        acc(0, IDX_MAIN_RESULT, 32'h0, 0);
        acc(0, IDX_SPARE_RESULT, 32'h0, 0);
        acc(0, 18'h0FF09, 32'h0, 1);
        acc(1, IDX_MAIN_RESULT, 32'hFFFFFFFF, 0);
        acc(1, IDX_SPARE_RESULT, 32'hFFFFFFFF, 0);
        acc(0, IDX_MAIN_RESULT, 32'h0, 0);
        acc(0, IDX_SPARE_RESULT, 32'h0, 0);
        acc(1, IDX_IRQ_MASK, 32'h1F, 0);
        fire(0, 0, ERR_ONE, 8'hFF, 4'hF, 2'h0);
        acc(0, IDX_MAIN_RESULT, 32'h0FFF, 0);
        irq_is(1);
        acc(0, IDX_IRQ_STATUS, 32'h01, 0);
        acc(1, IDX_IRQ_STATUS, 32'h01, 0);
        irq_is(0);
        fire(1, 0, ERR_ONE, 8'h00, 4'h1, 2'h0);
        acc(0, IDX_MAIN_RESULT, 32'h0001, 0);
        fire(0, 0, ERR_TWO, 8'h55, 4'h5, 2'h0);
        fire(0, 0, ERR_NONE, 8'h66, 4'h6, 2'h0);
        acc(0, IDX_MAIN_RESULT, 32'h0001, 0);
        fire(0, 1, ERR_ONE, 8'h00, 4'h5, CODE_WORD2);
        acc(0, IDX_SPARE_RESULT, 32'h0005, 0);
        fire(1, 1, ERR_ONE, 8'h00, 4'h7, CODE_WORD3);
        acc(0, IDX_SPARE_RESULT, 32'h0017, 0);
        fire(0, 1, ERR_ONE, 8'h00, 4'h8, CODE_WORD3);
        acc(0, IDX_SPARE_RESULT, 32'h0017, 0);
        fire(0, 1, ERR_ONE, 8'h00, 4'h1, 2'h2);
        fire(0, 1, ERR_ONE, 8'h00, 4'h2, 2'h3);
        acc(0, IDX_SPARE_RESULT, 32'h0017, 0);
        fire(0, 1, ERR_TWO, 8'h00, 4'h3, CODE_WORD2);
        acc(0, IDX_SPARE_RESULT, 32'h0017, 0);
        acc(0, IDX_MAIN_RESULT, 32'h0001, 0);
        acc(0, IDX_IRQ_STATUS, 32'h1F, 0);
        acc(1, IDX_IRQ_MASK, 32'h00, 0);
        irq_is(0);
        acc(1, IDX_IRQ_MASK, 32'h1F, 0);
        irq_is(1);
        acc(1, IDX_IRQ_STATUS, 32'h1F, 0);
        irq_is(0);
        // Four corrected and two uncorrectable checks so far
        acc(0, IDX_FIX_COUNT, 32'h4, 0);
        acc(0, IDX_FAIL_COUNT, 32'h2, 0);
        acc(1, IDX_FIX_COUNT, 32'h0, 0);
        acc(0, IDX_FIX_COUNT, 32'h0, 0);
        acc(1, 18'h0FF09, 32'hFFFFFFFF, 1);
        // Mid-run reset must return both results to zero
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        acc(0, IDX_SPARE_RESULT, 32'h0, 0);
        acc(0, IDX_MAIN_RESULT, 32'h0, 0);
        acc(0, IDX_FAIL_COUNT, 32'h0, 0);
        acc(0, IDX_IRQ_MASK, 32'h0, 0);
        test_done();
    end
endmodule : test_ecc4_result_regs

// ==== verilog/ecc4_capture.sv ====
// Capture of check results into the fourth-sector result fields
module ecc4_capture
    import ecc4_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Check result from the correction engine
    input wire logic chk_valid,
    input wire logic chk_boot,
    input wire logic chk_spare,
    input wire logic [1:0] chk_status,
    input wire logic [WORD_W-1:0] chk_word,
    input wire logic [LINE_W-1:0] chk_line,
    input wire logic [CODE_W-1:0] chk_code,
    // Result fields and events
    output logic [WORD_W-1:0] main_err_word_index_s4,
    output logic [LINE_W-1:0] main_err_line_index_s4,
    output logic [CODE_W-1:0] spare_err_word_code_s4,
    output logic [LINE_W-1:0] spare_err_line_index_s4,
    output logic [EV_W-1:0] events
);
    // ============================================================
    // State
    typedef struct packed {
        logic [WORD_W-1:0] mword;
        logic [LINE_W-1:0] mline;
        logic [CODE_W-1:0] scode;
        logic [LINE_W-1:0] sline;
        logic [EV_W-1:0] ev;
    } ecc4_cap_t;

    ecc4_cap_t st;
    ecc4_cap_t next_st;
    logic in_region;

    // ============================================================
    // Update logic
    always_comb
    begin
        next_st = st;
        next_st.ev = '0;
        // Low byte of the third word only; upper lines are unprotected
        in_region = (chk_code == CODE_WORD2) ||
            ((chk_code == CODE_WORD3) && (chk_line < WORD3_LINE_LIMIT));
        // Boot loading and normal loads update alike
        if (chk_valid && (chk_boot || !chk_boot))
        begin
            if (!chk_spare)
            begin
                if (chk_status == ERR_ONE)
                begin
                    next_st.mword = chk_word;
                    next_st.mline = chk_line;
                    next_st.ev[EV_MAIN_FIX] = 1'b1;
                end
                else if (chk_status == ERR_TWO)
                begin
                    next_st.ev[EV_MAIN_FAIL] = 1'b1;
                end
            end
            else
            begin
                if (chk_status == ERR_ONE && in_region)
                begin
                    next_st.scode = chk_code;
                    next_st.sline = chk_line;
                    next_st.ev[EV_SPARE_FIX] = 1'b1;
                end
                else if (chk_status == ERR_ONE)
                begin
                    next_st.ev[EV_SPARE_RANGE] = 1'b1;
                end
                else if (chk_status == ERR_TWO)
                begin
                    next_st.ev[EV_SPARE_FAIL] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign main_err_word_index_s4 = st.mword;
    assign main_err_line_index_s4 = st.mline;
    assign spare_err_word_code_s4 = st.scode;
    assign spare_err_line_index_s4 = st.sline;
    assign events = st.ev;
endmodule : ecc4_capture

// ==== verilog/ecc4_pkg.sv ====
// Constants for the fourth-sector correction result registers and capture
// ============================================================
// Package
package ecc4_pkg;
    // Register indices; byte address is four times the index
    localparam logic [17:0] IDX_MAIN_RESULT = 18'h0FF07;
    localparam logic [17:0] IDX_SPARE_RESULT = 18'h0FF08;
    localparam logic [17:0] IDX_IRQ_STATUS = 18'h0FF10;
    localparam logic [17:0] IDX_IRQ_MASK = 18'h0FF11;
    localparam logic [17:0] IDX_FIX_COUNT = 18'h0FF12;
    localparam logic [17:0] IDX_FAIL_COUNT = 18'h0FF13;
    localparam int IDX_W = 18;
    localparam int LANE_W = 2;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    // Field layout of both result words
    localparam int LINE_LSB = 0;
    localparam int LINE_W = 4;
    localparam int WORD_LSB = 4;
    localparam int WORD_W = 8;
    localparam int CODE_LSB = 4;
    localparam int CODE_W = 2;
    // Error status encoding from the check engine
    localparam logic [1:0] ERR_NONE = 2'h0;
    localparam logic [1:0] ERR_ONE = 2'h1;
    localparam logic [1:0] ERR_TWO = 2'h2;
    // Spare word codes
    localparam logic [1:0] CODE_WORD2 = 2'h0;
    localparam logic [1:0] CODE_WORD3 = 2'h1;
    // Only the low byte of the third spare word is protected
    localparam logic [3:0] WORD3_LINE_LIMIT = 4'h8;
    // Interrupt event bits
    localparam int EV_MAIN_FIX = 0;
    localparam int EV_MAIN_FAIL = 1;
    localparam int EV_SPARE_FIX = 2;
    localparam int EV_SPARE_FAIL = 3;
    localparam int EV_SPARE_RANGE = 4;
    localparam int EV_W = 5;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
endpackage : ecc4_pkg

// ==== verilog/ecc4_result_regs.sv ====
// APB register block for the fourth-sector correction results
// ============================================================
// Behaviour
// - Main word index in bits 11 to 4
// - Data line index in bits 3 to 0
// - Boot load also updates main fields
// - Boot load also updates spare fields
// - Spare log covers word two, third low byte
// - Spare code bits 5:4, 00 word2, 01 word3
// - Both result registers read-only, reset zero
// - Only corrected single-bit errors set positions
module ecc4_result_regs
    import ecc4_pkg::*;
#(
    parameter int ADDR_W = 20
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Check result from the correction engine
    input wire logic chk_valid,
    input wire logic chk_boot,
    input wire logic chk_spare,
    input wire logic [1:0] chk_status,
    input wire logic [WORD_W-1:0] chk_word,
    input wire logic [LINE_W-1:0] chk_line,
    input wire logic [CODE_W-1:0] chk_code,
    // Interrupt
    output logic irq
);
    // ============================================================
    // State
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
        logic [EV_W-1:0] irq_status;
        logic [EV_W-1:0] irq_mask;
        logic irq;
        logic [REG_W-1:0] fix_count;
        logic [REG_W-1:0] fail_count;
    } ecc4_regs_t;

    ecc4_regs_t st;
    ecc4_regs_t next_st;

    logic [WORD_W-1:0] main_word;
    logic [LINE_W-1:0] main_line;
    logic [CODE_W-1:0] spare_code;
    logic [LINE_W-1:0] spare_line;
    logic [EV_W-1:0] events;

    logic access;
    logic wr_done;
    logic hit_main;
    logic hit_spare;
    logic hit_stat;
    logic hit_mask;
    logic hit_fix;
    logic hit_fail;
    logic hit_any;
    logic [EV_W-1:0] stat_clear;
    logic [EV_W-1:0] stat_after;
    logic [DATA_W-1:0] rd_word;
    logic fix_ev;
    logic fail_ev;

    // ============================================================
    // Functions
    function automatic logic addr_is(
        input logic [ADDR_W-1:0] addr,
        input logic [IDX_W-1:0] idx
    );
        logic [ADDR_W-1:0] byte_addr;
        byte_addr = ADDR_W'({idx, {LANE_W{1'b0}}});
        return addr == byte_addr;
    endfunction : addr_is

    function automatic logic [DATA_W-1:0] widen(
        input logic [REG_W-1:0] value
    );
        return {{(DATA_W-REG_W){1'b0}}, value};
    endfunction : widen

    function automatic logic [REG_W-1:0] count_up(
        input logic [REG_W-1:0] value,
        input logic hit
    );
        // Saturate so software never sees a wrapped small count
        if (hit && value != COUNT_MAX)
        begin
            return value + COUNT_ONE;
        end
        return value;
    endfunction : count_up

    function automatic logic [REG_W-1:0] pack_main(
        input logic [WORD_W-1:0] word,
        input logic [LINE_W-1:0] line
    );
        logic [REG_W-1:0] r;
        r = RESULT_RESET;
        r[WORD_LSB +: WORD_W] = word;
        r[LINE_LSB +: LINE_W] = line;
        return r;
    endfunction : pack_main

    function automatic logic [REG_W-1:0] pack_spare(
        input logic [CODE_W-1:0] code,
        input logic [LINE_W-1:0] line
    );
        logic [REG_W-1:0] r;
        r = RESULT_RESET;
        r[CODE_LSB +: CODE_W] = code;
        r[LINE_LSB +: LINE_W] = line;
        return r;
    endfunction : pack_spare

    // ============================================================
    // Result capture
    ecc4_capture u_capture (
        .pclk(pclk),
        .presetn(presetn),
        .chk_valid(chk_valid),
        .chk_boot(chk_boot),
        .chk_spare(chk_spare),
        .chk_status(chk_status),
        .chk_word(chk_word),
        .chk_line(chk_line),
        .chk_code(chk_code),
        .main_err_word_index_s4(main_word),
        .main_err_line_index_s4(main_line),
        .spare_err_word_code_s4(spare_code),
        .spare_err_line_index_s4(spare_line),
        .events(events)
    );

    // ============================================================
    // Address decode
    always_comb
    begin
        hit_main = addr_is(paddr, IDX_MAIN_RESULT);
        hit_spare = addr_is(paddr, IDX_SPARE_RESULT);
        hit_stat = addr_is(paddr, IDX_IRQ_STATUS);
        hit_mask = addr_is(paddr, IDX_IRQ_MASK);
        hit_fix = addr_is(paddr, IDX_FIX_COUNT);
        hit_fail = addr_is(paddr, IDX_FAIL_COUNT);
        hit_any = hit_main | hit_spare | hit_stat | hit_mask |
            hit_fix | hit_fail;
    end

    // ============================================================
    // Read mux
    always_comb
    begin
        rd_word = '0;
        if (hit_main)
        begin
            rd_word = widen(pack_main(main_word, main_line));
        end
        else if (hit_spare)
        begin
            rd_word = widen(pack_spare(spare_code, spare_line));
        end
        else if (hit_stat)
        begin
            rd_word = {{(DATA_W-EV_W){1'b0}}, st.irq_status};
        end
        else if (hit_mask)
        begin
            rd_word = {{(DATA_W-EV_W){1'b0}}, st.irq_mask};
        end
        else if (hit_fix)
        begin
            rd_word = widen(st.fix_count);
        end
        else if (hit_fail)
        begin
            rd_word = widen(st.fail_count);
        end
    end

    // ============================================================
    // Next state
    always_comb
    begin
        next_st = st;
        // One wait state: ready rises in the second access cycle
        access = psel && penable;
        wr_done = access && st.pready && pwrite;
        next_st.pready = access && !st.pready;
        next_st.pslverr = 1'b0;
        if (access && !st.pready)
        begin
            next_st.prdata = pwrite ? '0 : rd_word;
            next_st.pslverr = !hit_any;
        end
        else
        begin
            // Read data stands only while pready does
            next_st.prdata = '0;
        end

        // Writes to the result registers fall through untouched
        stat_clear = '0;
        if (wr_done && hit_stat)
        begin
            stat_clear = pwdata[EV_W-1:0];
        end
        if (wr_done && hit_mask)
        begin
            next_st.irq_mask = pwdata[EV_W-1:0];
        end

        // A new event in the clearing cycle keeps its bit
        stat_after = (st.irq_status & ~stat_clear) | events;
        next_st.irq_status = stat_after;
        next_st.irq = |(stat_after & st.irq_mask);
        if (wr_done && hit_mask)
        begin
            next_st.irq = |(stat_after & pwdata[EV_W-1:0]);
        end

        // Each count clears on a write to its own register, but an event in that cycle counts
        fix_ev = events[EV_MAIN_FIX] | events[EV_SPARE_FIX];
        fail_ev = events[EV_MAIN_FAIL] | events[EV_SPARE_FAIL];
        if (wr_done && hit_fix)
        begin
            next_st.fix_count = fix_ev ? COUNT_ONE : '0;
        end
        else
        begin
            next_st.fix_count = count_up(st.fix_count, fix_ev);
        end
        if (wr_done && hit_fail)
        begin
            next_st.fail_count = fail_ev ? COUNT_ONE : '0;
        end
        else
        begin
            next_st.fail_count = count_up(st.fail_count, fail_ev);
        end
    end

    // ============================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign irq = st.irq;
endmodule : ecc4_result_regs
